/* File: logic/uei_regs.sv */
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module uei_regs #(
   parameter int ADDR_W = 12
) (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   input  wire logic              cts_event,
   input  wire logic              not_clear_to_send_event,
   input  wire logic              byte_received_event,
   input  wire logic              rx_end_event,
   input  wire logic              byte_sent_event,
   input  wire logic              tx_end_event,
   input  wire logic              rx_timeout_event,
   input  wire logic              rx_started_event,
   input  wire logic              tx_started_event,
   input  wire logic              tx_stopped_event,
   input  wire logic              rx_start_bit,
   input  wire logic              rx_holding_full,
   input  wire logic              rx_char_done,
   input  wire logic              rx_parity_bad,
   input  wire logic              rx_stop_bad,
   input  wire logic              parity_check_en,
   input  wire logic              bit_tick,
   input  wire logic              rxd,
   output logic                   receive_start_task,
   output logic                   receive_stop_task,
   output logic                   irq
);
   import uei_pkg::*;

   generate
      if (ADDR_W < 11) begin : g_chk
         $error("uei_regs: ADDR_W too narrow for register map");
      end
   endgenerate

   uei_bus_t            bus_st;
   logic [11:0]         addr;
   logic                wr_acc;
   logic [31:0]         wmask;
   logic [31:0]         next_rdata;
   logic [NUM_EV-1:0]   ev_set;
   logic [NUM_EV-1:0]   ev_wr;
   logic [NUM_EV-1:0]   flags;
   logic [NUM_EV-1:0]   irq_enable;
   logic                short_start;
   logic                short_stop;
   logic [NUM_ERR-1:0]  err_det;
   logic [NUM_ERR-1:0]  err_src;
   logic                brk_pulse;
   logic                irq_src;

   function automatic logic [31:0] be_mask(input logic [3:0] be);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction

   function automatic logic [31:0] pack_en(input logic [NUM_EV-1:0] en);
      logic [31:0] w;
      w = '0;
      for (int i = 0; i < NUM_EV; i++) begin
         w[EV_BIT[i]] = en[i];
      end
      return w;
   endfunction

   assign addr  = 12'(avs_address);
   assign wmask = be_mask(avs_byteenable);

   // Bus: one wait cycle, then a single cycle with waitrequest low
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bus_st          <= UEI_IDLE;
         avs_waitrequest <= 1'b1;
      end else begin
         case (bus_st)
            UEI_IDLE: begin
               if (avs_read || avs_write) begin
                  bus_st          <= UEI_ACK;
                  avs_waitrequest <= 1'b0;
               end
            end
            UEI_ACK: begin
               bus_st          <= UEI_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               bus_st          <= UEI_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // Writes land at the edge where the master sees waitrequest low
   assign wr_acc = avs_write && (bus_st == UEI_ACK);

   // Unmapped addresses read as zero
   always_comb begin
      next_rdata = '0;
      if (addr == OFS_SHORTCUT_CONTROL) begin
         next_rdata[SH_START] = short_start;
         next_rdata[SH_STOP]  = short_stop;
      end else if (addr == OFS_IRQ_ENABLE) begin
         next_rdata = pack_en(irq_enable);
      end else if (addr == OFS_INTSET) begin
         next_rdata = pack_en(irq_enable);
      end else if (addr == OFS_INTCLR) begin
         next_rdata = pack_en(irq_enable);
      end else if (addr == OFS_ERRSRC) begin
         next_rdata[NUM_ERR-1:0] = err_src;
      end else begin
         for (int i = 0; i < NUM_EV; i++) begin
            if (addr == EV_OFS[i]) begin
               next_rdata[0] = flags[i];
            end
         end
      end
   end

   // Read data sampled when the request is first seen
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         avs_readdata <= RST_VAL;
      end else if (bus_st == UEI_IDLE && avs_read) begin
         avs_readdata <= next_rdata;
      end
   end

   // Error detectors
   uei_break_det #(
      .CNT_W (4)
   ) u_brk (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .rxd         (rxd),
      .bit_tick    (bit_tick),
      .parity_en   (parity_check_en),
      .break_pulse (brk_pulse)
   );

   assign err_det[ERR_OVR] = rx_start_bit && rx_holding_full;
   assign err_det[ERR_PAR] = rx_char_done && rx_parity_bad && parity_check_en;
   assign err_det[ERR_FRM] = rx_char_done && rx_stop_bad;
   assign err_det[ERR_BRK] = brk_pulse;

   // Error cause bits: a new error wins over a clearing write
   generate
      for (genvar e = 0; e < NUM_ERR; e++) begin : g_err
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               err_src[e] <= RST_VAL[e];
            end else if (err_det[e]) begin
               err_src[e] <= 1'b1;
            end else if (wr_acc && addr == OFS_ERRSRC && wmask[e] && avs_writedata[e]) begin
               err_src[e] <= 1'b0;
            end
         end
      end
   endgenerate

   // Event flags, order fixed by the EV_ indices
   assign ev_set[EV_CTS]    = cts_event;
   assign ev_set[EV_NOT_CLEAR_TO_SEND_EVENT]   = not_clear_to_send_event;
   assign ev_set[EV_RXRDY]  = byte_received_event;
   assign ev_set[EV_RXEND]  = rx_end_event;
   assign ev_set[EV_TXRDY]  = byte_sent_event;
   assign ev_set[EV_TXEND]  = tx_end_event;
   assign ev_set[EV_ERR]    = |err_det;
   assign ev_set[EV_RX_TIMEOUT_EVENT]   = rx_timeout_event;
   assign ev_set[EV_RXST]   = rx_started_event;
   assign ev_set[EV_TXST]   = tx_started_event;
   assign ev_set[EV_TXSTOP] = tx_stopped_event;

   generate
      for (genvar i = 0; i < NUM_EV; i++) begin : g_ev
         assign ev_wr[i] = wr_acc && (addr == EV_OFS[i]) && avs_byteenable[0];
         uei_event_flag u_flag (
            .core_clk  (core_clk),
            .rst_n     (rst_n),
            .set_pulse (ev_set[i]),
            .wr_en     (ev_wr[i]),
            .wr_bit    (avs_writedata[0]),
            .flag      (flags[i])
         );
      end
   endgenerate

   // Shortcut control
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         short_start <= RST_VAL[SH_START];
         short_stop  <= RST_VAL[SH_STOP];
      end else if (wr_acc && addr == OFS_SHORTCUT_CONTROL && avs_byteenable[0]) begin
         short_start <= avs_writedata[SH_START];
         short_stop  <= avs_writedata[SH_STOP];
      end
   end

   // Task strobes registered; one cycle behind the receive-end strobe
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         receive_start_task <= 1'b0;
         receive_stop_task  <= 1'b0;
      end else begin
         receive_start_task <= rx_end_event && short_start;
         receive_stop_task  <= rx_end_event && short_stop;
      end
   end

   // One enable set shared by all three aliases
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_enable <= '0;
      end else if (wr_acc) begin
         for (int i = 0; i < NUM_EV; i++) begin
            if (wmask[EV_BIT[i]]) begin
               if (addr == OFS_IRQ_ENABLE) begin
                  irq_enable[i] <= avs_writedata[EV_BIT[i]];
               end else if (addr == OFS_INTSET && avs_writedata[EV_BIT[i]]) begin
                  irq_enable[i] <= 1'b1;
               end else if (addr == OFS_INTCLR && avs_writedata[EV_BIT[i]]) begin
                  irq_enable[i] <= 1'b0;
               end
            end
         end
      end
   end

   // Level interrupt, registered so the pin never glitches
   assign irq_src = |(flags & irq_enable);
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_src;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   AST_RX_TIMEOUT_EVENT_SET: assert property (rx_timeout_event |=> flags[EV_RX_TIMEOUT_EVENT])
      else $error("timeout flag not set");

   AST_TXEND_SET: assert property (tx_end_event |=> flags[EV_TXEND])
      else $error("tx end flag not set");

   AST_RXST_SET: assert property (rx_started_event |=> flags[EV_RXST])
      else $error("receiver started flag not set");

   AST_TXST_SET: assert property (tx_started_event |=> flags[EV_TXST])
      else $error("transmitter started flag not set");

   AST_SHORT_START: assert property (rx_end_event |=>
      receive_start_task == $past(short_start))
      else $error("start link wrong");

   AST_SHORT_STOP: assert property (rx_end_event ##1 !receive_stop_task
      |-> !$past(short_stop))
      else $error("stop link missed");

   AST_NO_TASK: assert property (!rx_end_event |=>
      !receive_start_task && !receive_stop_task)
      else $error("task without receive end");

   AST_EN_SET: assert property (wr_acc && addr == OFS_INTSET
      && avs_byteenable[2] && avs_writedata[EV_BIT[EV_RX_TIMEOUT_EVENT]]
      |=> irq_enable[EV_RX_TIMEOUT_EVENT] && avs_waitrequest)
      else $error("enable set failed");

   AST_EN_CLR: assert property (wr_acc && addr == OFS_INTCLR
      && avs_byteenable[1] && avs_writedata[EV_BIT[EV_ERR]]
      |=> !irq_enable[EV_ERR])
      else $error("enable clear failed");

   AST_IRQ: assert property (##1 irq == $past(irq_src))
      else $error("irq mismatch");

   AST_ERR_W1C: assert property (wr_acc && addr == OFS_ERRSRC
      && avs_byteenable[0] && avs_writedata[ERR_FRM] && !err_det[ERR_FRM]
      |=> !err_src[ERR_FRM])
      else $error("error bit not cleared");

   AST_OVR: assert property (rx_start_bit && rx_holding_full
      |=> err_src[ERR_OVR] && flags[EV_ERR])
      else $error("overrun not recorded");

   AST_PAR_GATE: assert property (!err_src[ERR_PAR] &&
      !(rx_char_done && rx_parity_bad && parity_check_en)
      |=> !err_src[ERR_PAR])
      else $error("parity set without cause");

   AST_FRM: assert property (rx_char_done && rx_stop_bad
      |=> err_src[ERR_FRM])
      else $error("framing not recorded");

   AST_RXEND_SET: assert property (rx_end_event |=> flags[EV_RXEND])
      else $error("receive end flag not set");

   AST_BRK: assert property (brk_pulse |=> err_src[ERR_BRK] && flags[EV_ERR])
      else $error("break not recorded");

   AST_ERR_EV: assert property ($rose(|err_src) |-> flags[EV_ERR])
      else $error("error event missing");

   AST_BUS_ACK: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer late");

   COV_SHORT: cover property (rx_end_event && short_start ##1 receive_start_task);
   COV_IRQ: cover property ($rose(irq));
   COV_BREAK: cover property (brk_pulse ##1 err_src[ERR_BRK]);
   COV_CLR: cover property (wr_acc && addr == OFS_INTCLR ##1 !irq);
   COV_ERR_CLR: cover property (wr_acc && addr == OFS_ERRSRC ##1 err_src == '0);
endmodule
`default_nettype wire

/* File: common/uei_pkg.sv */
`default_nettype none
package uei_pkg;
   localparam int NUM_EV = 11;
   localparam int NUM_ERR = 4;

   // Event flag order, also the index into the flag vector
   localparam int EV_CTS    = 0;
   localparam int EV_NOT_CLEAR_TO_SEND_EVENT   = 1;
   localparam int EV_RXRDY  = 2;
   localparam int EV_RXEND  = 3;
   localparam int EV_TXRDY  = 4;
   localparam int EV_TXEND  = 5;
   localparam int EV_ERR    = 6;
   localparam int EV_RX_TIMEOUT_EVENT   = 7;
   localparam int EV_RXST   = 8;
   localparam int EV_TXST   = 9;
   localparam int EV_TXSTOP = 10;

   // Byte offsets of the event flag registers, same order
   localparam logic [11:0] EV_OFS [NUM_EV] = '{
      12'h100, 12'h104, 12'h108, 12'h110, 12'h11c, 12'h120,
      12'h124, 12'h144, 12'h14c, 12'h150, 12'h158};

   // Bit of each event in the enable registers, same order
   localparam int EV_BIT [NUM_EV] = '{0, 1, 2, 4, 7, 8, 9, 17, 19, 20, 22};

   localparam logic [11:0] OFS_SHORTCUT_CONTROL = 12'h200;
   localparam logic [11:0] OFS_IRQ_ENABLE  = 12'h300;
   localparam logic [11:0] OFS_INTSET = 12'h304;
   localparam logic [11:0] OFS_INTCLR = 12'h308;
   localparam logic [11:0] OFS_ERRSRC = 12'h480;

   localparam int SH_START = 5;
   localparam int SH_STOP  = 6;

   localparam int ERR_OVR = 0;
   localparam int ERR_PAR = 1;
   localparam int ERR_FRM = 2;
   localparam int ERR_BRK = 3;

   localparam logic [31:0] RST_VAL = 32'h0000_0000;

   localparam int FRAME_NOPAR = 10;
   localparam int FRAME_PAR   = 11;

   typedef enum logic [0:0] {
      UEI_IDLE = 1'b0,
      UEI_ACK  = 1'b1
   } uei_bus_t;
endpackage
`default_nettype wire

/* File: logic/uei_event_flag.sv */
`timescale 1ns/1ps
`default_nettype none
module uei_event_flag (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic set_pulse,
   input  wire logic wr_en,
   input  wire logic wr_bit,
   output logic      flag
);
   import uei_pkg::*;

   // Hardware set wins over a software write in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         flag <= RST_VAL[0];
      end else if (set_pulse) begin
         flag <= 1'b1;
      end else if (wr_en) begin
         flag <= wr_bit;
      end
   end
endmodule
`default_nettype wire

/* File: logic/uei_break_det.sv */
`timescale 1ns/1ps
`default_nettype none
module uei_break_det #(
   parameter int CNT_W = 4
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic rxd,
   input  wire logic bit_tick,
   input  wire logic parity_en,
   output logic      break_pulse
);
   import uei_pkg::*;

   generate
      if ((2 ** CNT_W) <= FRAME_PAR + 1) begin : g_chk
         $error("uei_break_det: CNT_W too small for frame length");
      end
   endgenerate

   logic             rxd_meta;
   logic             rxd_sync;
   logic [CNT_W-1:0] low_cnt;
   logic [CNT_W-1:0] frame_len;
   logic             fired;

   // Pin is asynchronous; idle line is high
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rxd_meta <= 1'b1;
         rxd_sync <= 1'b1;
      end else begin
         rxd_meta <= rxd;
         rxd_sync <= rxd_meta;
      end
   end

   assign frame_len = parity_en ? CNT_W'(FRAME_PAR) : CNT_W'(FRAME_NOPAR);

   // Longer than a frame: fire on the tick after frame_len low ticks
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         low_cnt     <= '0;
         fired       <= 1'b0;
         break_pulse <= 1'b0;
      end else begin
         break_pulse <= 1'b0;
         if (rxd_sync) begin
            low_cnt <= '0;
            fired   <= 1'b0;
         end else if (bit_tick && !fired) begin
            if (low_cnt == frame_len) begin
               break_pulse <= 1'b1;
               fired       <= 1'b1;
            end else begin
               low_cnt <= low_cnt + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: verif/uei_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module uei_regs_test;
   import uei_pkg::*;
   localparam int P_START = 11;
   localparam int P_DONE  = 12;
   localparam int P_TICK  = 13;
   logic        core_clk;
   logic        rst_n;
   logic [11:0] avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [13:0] pv;
   logic        rx_holding_full;
   logic        rx_parity_bad;
   logic        rx_stop_bad;
   logic        parity_check_en;
   logic        rxd;
   logic        receive_start_task;
   logic        receive_stop_task;
   logic        irq;
   logic [31:0] exp_q[$];
   int          err_count;
   int          cmp_count;
   logic [31:0] en_mask;
   logic [31:0] r;
   logic [31:0] e;

   uei_regs u_uei_regs (
      .core_clk                (core_clk),
      .rst_n                   (rst_n),
      .avs_address             (avs_address),
      .avs_read                (avs_read),
      .avs_write               (avs_write),
      .avs_writedata           (avs_writedata),
      .avs_byteenable          (4'hf),
      .avs_readdata            (avs_readdata),
      .avs_waitrequest         (avs_waitrequest),
      .cts_event               (pv[EV_CTS]),
      .not_clear_to_send_event (pv[EV_NOT_CLEAR_TO_SEND_EVENT]),
      .byte_received_event     (pv[EV_RXRDY]),
      .rx_end_event            (pv[EV_RXEND]),
      .byte_sent_event         (pv[EV_TXRDY]),
      .tx_end_event            (pv[EV_TXEND]),
      .rx_timeout_event        (pv[EV_RX_TIMEOUT_EVENT]),
      .rx_started_event        (pv[EV_RXST]),
      .tx_started_event        (pv[EV_TXST]),
      .tx_stopped_event        (pv[EV_TXSTOP]),
      .rx_start_bit            (pv[P_START]),
      .rx_holding_full         (rx_holding_full),
      .rx_char_done            (pv[P_DONE]),
      .rx_parity_bad           (rx_parity_bad),
      .rx_stop_bad             (rx_stop_bad),
      .parity_check_en         (parity_check_en),
      .bit_tick                (pv[P_TICK]),
      .rxd                     (rxd),
      .receive_start_task      (receive_start_task),
      .receive_stop_task       (receive_stop_task),
      .irq                     (irq)
   );

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic print_verdict();
      if (err_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   // Holds the request until waitrequest is seen low; no fixed latency assumed
   task automatic bus(input logic is_wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= ~is_wr;
      avs_write     <= is_wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         err_count++;
      end
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      exp_q.push_back(exp);
      bus(1'b0, a, 32'h0000_0000);
   endtask

   // One-cycle strobe on an event, detector or tick input
   task automatic pl(input int k);
      @(posedge core_clk);
      pv[k] <= 1'b1;
      @(posedge core_clk);
      pv[k] <= 1'b0;
   endtask

   // Read data are taken only at the edge that ends the wait
   always @(posedge core_clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0) begin
            chk(32'hffff_ffff, avs_readdata);
         end else begin
            chk(exp_q.pop_front(), avs_readdata);
         end
      end
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      print_verdict();
   end

   initial begin
      rst_n = 1'b0;
      avs_address = 12'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      pv = 14'h0000;
      rx_holding_full = 1'b0;
      rx_parity_bad = 1'b0;
      rx_stop_bad = 1'b0;
      parity_check_en = 1'b0;
      rxd = 1'b1;
      err_count = 0;
      cmp_count = 0;
      en_mask = 32'h0000_0000;
      void'($urandom(37545));
      for (int i = 0; i < NUM_EV; i++) en_mask[EV_BIT[i]] = 1'b1;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      // Reset values, then an unmapped word that must stay empty
      for (int i = 0; i < NUM_EV; i++) rd(EV_OFS[i], RST_VAL);
      rd(OFS_SHORTCUT_CONTROL, RST_VAL);
      rd(OFS_IRQ_ENABLE, RST_VAL);
      rd(OFS_ERRSRC, RST_VAL);
      wr(12'h500, $urandom);
      rd(12'h500, 32'h0000_0000);
      // Three views of one enable word
      for (int k = 0; k < 3; k++) begin
         r = $urandom;
         wr(OFS_IRQ_ENABLE, r);
         e = r & en_mask;
         rd(OFS_IRQ_ENABLE, e);
         rd(OFS_INTCLR, e);
         r = $urandom;
         wr(OFS_INTSET, r);
         e = (e | r) & en_mask;
         rd(OFS_IRQ_ENABLE, e);
         r = $urandom;
         wr(OFS_INTCLR, r);
         e = e & ~r;
         rd(OFS_INTSET, e);
      end
      // Each event except the error event sets its flag; irq follows only an enabled flag
      for (int i = 0; i < NUM_EV; i++) begin
         if (i != EV_ERR) begin
            wr(OFS_INTCLR, 32'hffff_ffff);
            wr(OFS_INTSET, 32'h1 << EV_BIT[i]);
            pl(i);
            @(posedge core_clk);
            #1 chk(32'h1, irq);
            rd(EV_OFS[i], 32'h1);
            wr(EV_OFS[i], 32'h0);
            rd(EV_OFS[i], 32'h0);
            chk(32'h0, irq);
            wr(OFS_INTCLR, 32'h1 << EV_BIT[i]);
            pl(i);
            @(posedge core_clk);
            #1 chk(32'h0, irq);
            wr(EV_OFS[i], 32'h0);
         end
      end
      // All four shortcut settings against a receive-end strobe
      for (int s = 0; s < 4; s++) begin
         wr(OFS_SHORTCUT_CONTROL, s << SH_START);
         rd(OFS_SHORTCUT_CONTROL, s << SH_START);
         pl(EV_RXEND);
         #1 chk(s[0], receive_start_task);
         chk(s[1], receive_stop_task);
         @(posedge core_clk);
         #1 chk(2'b00, {receive_start_task, receive_stop_task});
      end
      // Error detectors, qualified and unqualified
      pl(P_START);
      rd(OFS_ERRSRC, 32'h0);
      rx_holding_full <= 1'b1;
      pl(P_START);
      rd(OFS_ERRSRC, 32'h1);
      rx_parity_bad <= 1'b1;
      pl(P_DONE);
      rd(OFS_ERRSRC, 32'h1);
      parity_check_en <= 1'b1;
      pl(P_DONE);
      rd(OFS_ERRSRC, 32'h3);
      rx_stop_bad <= 1'b1;
      pl(P_DONE);
      rd(OFS_ERRSRC, 32'h7);
      rd(EV_OFS[EV_ERR], 32'h1);
      wr(EV_OFS[EV_ERR], 32'h0);
      wr(OFS_ERRSRC, 32'h5);
      rd(OFS_ERRSRC, 32'h2);
      wr(OFS_ERRSRC, 32'h0);
      rd(OFS_ERRSRC, 32'h2);
      wr(OFS_ERRSRC, 32'hf);
      rd(OFS_ERRSRC, 32'h0);
      // Break: frame is ten ticks, eleven with parity
      for (int p = 0; p < 2; p++) begin
         parity_check_en <= p[0];
         rxd <= 1'b0;
         repeat (3) @(posedge core_clk);
         repeat (FRAME_NOPAR + p) pl(P_TICK);
         rd(OFS_ERRSRC, 32'h0);
         pl(P_TICK);
         rd(OFS_ERRSRC, 32'h8);
         rd(EV_OFS[EV_ERR], 32'h1);
         rxd <= 1'b1;
         repeat (3) pl(P_TICK);
         wr(OFS_ERRSRC, 32'hf);
         wr(EV_OFS[EV_ERR], 32'h0);
      end
      repeat (4) @(posedge core_clk);
      print_verdict();
   end
endmodule
`default_nettype wire
